// *** logic/sau_agen.sv ***
// Address arithmetic for the store unit: linear or circular add/subtract.
// Assumes the caller has already scaled the offset.
`timescale 1ns/100ps
module sau_agen
  import sau_pkg::*;
(
  // Operands and result
  sau_agen_if.calc ag
);

  logic [31:0] sum;
  logic [32:0] blkSize;
  logic [31:0] mask;

  // Circular block is 2^(N+1) bytes; upper bits of the base stay put
  always_comb begin
    sum     = ag.subtract ? ag.base - ag.offset : ag.base + ag.offset;
    blkSize = 33'h0_0000_0002 << ag.blkExp;
    mask    = 32'(blkSize - 33'h0_0000_0001);
    if (ag.circular) begin
      ag.result = (ag.base & ~mask) | (sum & mask);
    end else begin
      ag.result = sum;
    end
  end

endmodule

// *** logic/sau_agen_if.sv ***
// Carrier between the store unit and its address generator.
// Assumes the generator is purely combinational.
`timescale 1ns/100ps
interface sau_agen_if;
  logic [31:0] base;
  logic [31:0] offset;
  logic        subtract;
  logic        circular;
  logic [4:0]  blkExp;
  logic [31:0] result;

  modport req (output base, output offset, output subtract,
               output circular, output blkExp, input result);
  modport calc (input base, input offset, input subtract,
                input circular, input blkExp, output result);
endinterface

// *** logic/sau_pkg.sv ***
// Constants and types shared by the store address unit.
// Assumes one 200 MHz core clock and an APB register port.
//
// Contract
// - Long form takes base from global base zero when y=0, one when y=1.
// - Long form runs only on data unit two, never on unit one.
// - Offset shifts left by 0, 1, 2 for byte, halfword, word stores.
// - Long form stores at base plus scaled offset; base register unchanged.
// - Long form address arithmetic is always linear; circular setup ignored.
// - Byte stores low 8 bits, halfword low 16, word all 32 bits.
// - Source comes from file A when s=0, file B when s=1.
// - Access field 011 byte, 101 halfword, 111 word.
// - Register form reads operands and writes base in first execute stage.
// - Pre-modified base is visible one cycle after issue.
// - Store data lands in memory three cycles after issue, not one.
// - Post modes send the old base; pre and offset modes send the sum.
// - Register form y=0 uses unit one and file A; y=1 unit two, file B.
// - Register form is linear, circular allowed for bases 4..7 per mode control.
package sau_pkg;

  // APB map, byte addresses
  localparam logic [11:0] REG_AMODE   = 12'h000;
  localparam logic [11:0] REG_COUNT   = 12'h004;
  localparam logic [11:0] REG_LASTADR = 12'h008;
  localparam logic [11:0] REG_FAULT   = 12'h00C;

  localparam logic [31:0] AMODE_RST   = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  // Addressing mode control: 2-bit field per base 4..7, A file then B file
  localparam int          AM_FLD_W    = 2;
  localparam int          AM_B_OFS    = 8;
  localparam int          AM_BK0_LSB  = 16;
  localparam int          AM_BK1_LSB  = 21;
  localparam logic [1:0]  AM_LINEAR   = 2'h0;
  localparam logic [1:0]  AM_CIRC_BK0 = 2'h1;

  // Fault register bits
  localparam int          FLT_ALIGN   = 0;
  localparam int          FLT_ACCESS  = 1;

  // Access type field
  localparam logic [2:0]  ACC_BYTE    = 3'h3;
  localparam logic [2:0]  ACC_HALF    = 3'h5;
  localparam logic [2:0]  ACC_WORD    = 3'h7;

  // Address generator mode bits
  localparam int          MD_ADD      = 0;
  localparam int          MD_POST     = 1;
  localparam int          MD_REGOFS   = 2;
  localparam int          MD_MODIFY   = 3;

  // Issue to store data landing in memory, in cycles
  localparam int          STORE_LAT   = 3;

  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} sau_size_t;

  typedef struct packed {
    logic        e2Vld;
    logic [31:0] e2Addr;
    logic [31:0] e2Data;
    logic [3:0]  e2Be;
    logic        memVld;
    logic [31:0] memAddr;
    logic [31:0] memData;
    logic [3:0]  memBe;
    logic        wbVld;
    logic        wbFileB;
    logic [4:0]  wbIdx;
    logic [31:0] wbData;
    logic [31:0] amode;
    logic [31:0] count;
    logic [31:0] lastAdr;
    logic [1:0]  fault;
    logic [31:0] rdData;
    logic        slvErr;
  } sau_state_t;

endpackage

// *** logic/sau_store_unit.sv ***
// Store execution unit: effective address, source select, lane steering,
// base write-back and a small APB block for mode, count and fault status.
// Assumes operands arrive in the issue cycle from the register files and
// that the memory port accepts a write every cycle without stalling.
// Pipeline: the issue cycle computes, the base write-back is seen one cycle
// later, the memory strobe stands in the third cycle and lands at its end.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module sau_store_unit
  import sau_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Issue from the pipeline
  input  wire logic        issueValid,
  input  wire logic        issuePredTrue,
  input  wire logic        issueLongForm,
  input  wire logic        issueBaseSel,
  input  wire logic        issueSrcSel,
  input  wire logic [2:0]  issueAccess,
  input  wire logic [3:0]  issueMode,
  input  wire logic [4:0]  issueBaseIdx,
  input  wire logic [14:0] issueOffsetField,
  // Register file operands
  input  wire logic [31:0] baseValA,
  input  wire logic [31:0] baseValB,
  input  wire logic [31:0] offsetValA,
  input  wire logic [31:0] offsetValB,
  input  wire logic [31:0] srcValA,
  input  wire logic [31:0] srcValB,
  input  wire logic [31:0] globalBaseZero,
  input  wire logic [31:0] globalBaseOne,
  // Unit occupancy
  output logic             unitOneBusy,
  output logic             unitTwoBusy,
  // Base write-back
  output logic             baseWrEn,
  output logic             baseWrFileB,
  output logic [4:0]       baseWrIdx,
  output logic [31:0]      baseWrData,
  // Data memory port
  output logic             memWrEn,
  output logic [31:0]      memAddr,
  output logic [31:0]      memWrData,
  output logic [3:0]       memByteEn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  sau_state_t s;
  sau_state_t n;

  // Address arithmetic lives in its own module, shared by both forms
  sau_agen_if ag ();

  sau_agen u_agen (
    .ag (ag.calc)
  );

  ////////////////////////////////////////////////////////////////////
  // Decode

  sau_size_t   size;
  logic        accOk;
  logic        fire;
  logic [1:0]  shAmt;
  logic [31:0] rawOffset;
  logic [31:0] scaledOffset;
  logic [31:0] srcVal;
  logic [31:0] regBase;
  logic [31:0] effAddr;
  logic        circReg;
  logic [1:0]  circFld;
  logic        misaligned;

  // Codes outside the three legal ones set a fault when the predicate is true, and store nothing
  always_comb begin
    size  = SZ_WORD;
    accOk = 1'b1;
    shAmt = 2'd2;
    case (issueAccess)
      ACC_BYTE: begin
        size  = SZ_BYTE;
        shAmt = 2'd0;
      end
      ACC_HALF: begin
        size  = SZ_HALF;
        shAmt = 2'd1;
      end
      ACC_WORD: begin
        size  = SZ_WORD;
        shAmt = 2'd2;
      end
      default: begin
        accOk = 1'b0;
      end
    endcase
  end

  // A false predicate turns the store into a no-operation
  assign fire = issueValid & issuePredTrue & accOk;

  // Source file is independent of the unit used
  assign srcVal = issueSrcSel ? srcValB : srcValA;

  ////////////////////////////////////////////////////////////////////
  // Address generation

  // The long form zero-extends its 15-bit field; the short form keeps only
  // five bits of the same field, so stale upper bits cannot leak in
  always_comb begin
    if (issueLongForm) begin
      rawOffset = {17'h0_0000, issueOffsetField};
    end else if (issueMode[MD_REGOFS]) begin
      rawOffset = issueBaseSel ? offsetValB : offsetValA;
    end else begin
      rawOffset = {27'h000_0000, issueOffsetField[4:0]};
    end
    scaledOffset = rawOffset << shAmt;
  end

  // Register form: one select bit picks unit, base file and offset file together
  assign regBase = issueBaseSel ? baseValB : baseValA;

  // Only bases 4..7 have a mode field; others are always linear
  assign circReg = (issueBaseIdx[4:2] == 3'h1);
  // File A fields start at bit 0, file B fields right after them
  assign circFld = s.amode[(issueBaseSel ? AM_B_OFS : 0)
                           + issueBaseIdx[1:0] * AM_FLD_W +: AM_FLD_W];

  // The long form never looks at the mode control, so a circular setup left
  // by software for other bases cannot bend its address
  always_comb begin
    if (issueLongForm) begin
      ag.base     = issueBaseSel ? globalBaseOne : globalBaseZero;
      ag.offset   = scaledOffset;
      ag.subtract = 1'b0;
      ag.circular = 1'b0;
      ag.blkExp   = 5'h00;
    end else begin
      ag.base     = regBase;
      ag.offset   = scaledOffset;
      ag.subtract = ~issueMode[MD_ADD];
      ag.circular = circReg & (circFld != AM_LINEAR);
      ag.blkExp   = (circFld == AM_CIRC_BK0) ? s.amode[AM_BK0_LSB +: 5]
                                             : s.amode[AM_BK1_LSB +: 5];
    end
  end

  // Post modes hand the unmodified base to memory
  always_comb begin
    if (!issueLongForm && issueMode[MD_MODIFY] && issueMode[MD_POST]) begin
      effAddr = regBase;
    end else begin
      effAddr = ag.result;
    end
  end

  // Software is expected to align; a slip is recorded, not corrected
  always_comb begin
    case (size)
      SZ_HALF: misaligned = effAddr[0];
      SZ_WORD: misaligned = effAddr[1:0] != 2'h0;
      default: misaligned = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Byte lane steering

  // Data is replicated across lanes so memory needs only the byte enables;
  // a misaligned address still steers by its low bits
  logic [31:0] laneData;
  logic [3:0]  laneBe;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      always_comb begin
        case (size)
          SZ_BYTE: begin
            laneData[lane*8 +: 8] = srcVal[7:0];
            laneBe[lane]          = (effAddr[1:0] == 2'(lane));
          end
          SZ_HALF: begin
            laneData[lane*8 +: 8] = srcVal[(lane % 2)*8 +: 8];
            laneBe[lane]          = (effAddr[1] == 1'(lane / 2));
          end
          default: begin
            laneData[lane*8 +: 8] = srcVal[lane*8 +: 8];
            laneBe[lane]          = 1'b1;
          end
        endcase
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Unit occupancy

  // The long form is forced onto unit two whatever was requested
  // A refused store still occupies its unit, since the issue slot was used
  always_comb begin
    unitOneBusy = 1'b0;
    unitTwoBusy = 1'b0;
    if (issueValid) begin
      if (issueLongForm) begin
        unitTwoBusy = 1'b1;
      end else begin
        unitOneBusy = ~issueBaseSel;
        unitTwoBusy = issueBaseSel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  // Register map: mode control, store count, last address (read only) and
  // fault flags (write one to clear). Reads are captured in the setup cycle,
  // so the access cycle can answer at once with no wait state.
  logic apbSetup;
  logic apbWrite;

  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;

  always_comb begin
    n = s;
    // Fields not named below hold their value

    // Second execute stage holds the store
    n.e2Vld  = fire;
    n.e2Addr = effAddr;
    n.e2Data = laneData;
    n.e2Be   = laneBe;

    // Third stage drives the memory write; data lands at the next edge
    n.memVld  = s.e2Vld;
    n.memAddr = s.e2Addr;
    n.memData = s.e2Data;
    n.memBe   = s.e2Be;

    // Base update is written in the issue stage, seen one cycle later
    n.wbVld   = fire & ~issueLongForm & issueMode[MD_MODIFY];
    n.wbFileB = issueBaseSel;
    n.wbIdx   = issueBaseIdx;
    n.wbData  = ag.result;

    // A software write to the counter in the same cycle takes precedence
    if (fire) begin
      n.count   = s.count + 32'h0000_0001;
      n.lastAdr = effAddr;
    end

    // Register writes; hardware set wins over a clear in the same cycle
    if (apbWrite) begin
      case (paddr)
        REG_AMODE: n.amode = pwdata;
        REG_COUNT: n.count = pwdata;
        REG_FAULT: n.fault = s.fault & ~pwdata[1:0];
        default:   n.amode = s.amode;
      endcase
    end
    if (fire && misaligned) begin
      n.fault[FLT_ALIGN] = 1'b1;
    end
    if (issueValid && issuePredTrue && !accOk) begin
      n.fault[FLT_ACCESS] = 1'b1;
    end

    // Read data and error are captured in the setup cycle
    // An unmapped read returns zero and flags an error in the access cycle
    if (apbSetup) begin
      n.slvErr = 1'b0;
      case (paddr)
        REG_AMODE:   n.rdData = s.amode;
        REG_COUNT:   n.rdData = s.count;
        REG_LASTADR: n.rdData = s.lastAdr;
        REG_FAULT:   n.rdData = {30'h0000_0000, s.fault};
        default: begin
          n.rdData = ZERO_WORD;
          n.slvErr = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  // Every field has an explicit reset value so no unknown leaks out
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s.e2Vld   <= 1'b0;
      s.e2Addr  <= ZERO_WORD;
      s.e2Data  <= ZERO_WORD;
      s.e2Be    <= 4'h0;
      s.memVld  <= 1'b0;
      s.memAddr <= ZERO_WORD;
      s.memData <= ZERO_WORD;
      s.memBe   <= 4'h0;
      s.wbVld   <= 1'b0;
      s.wbFileB <= 1'b0;
      s.wbIdx   <= 5'h00;
      s.wbData  <= ZERO_WORD;
      s.amode   <= AMODE_RST;
      s.count   <= ZERO_WORD;
      s.lastAdr <= ZERO_WORD;
      s.fault   <= 2'h0;
      s.rdData  <= ZERO_WORD;
      s.slvErr  <= 1'b0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  // Data outputs come straight from flip-flops
  assign baseWrEn    = s.wbVld;
  assign baseWrFileB = s.wbFileB;
  assign baseWrIdx   = s.wbIdx;
  assign baseWrData  = s.wbData;

  assign memWrEn   = s.memVld;
  assign memAddr   = s.memAddr;
  assign memWrData = s.memData;
  assign memByteEn = s.memBe;

  // Single access cycle: answer is ready as soon as penable rises
  assign pready  = psel & penable;
  assign prdata  = s.rdData;
  assign pslverr = psel & penable & s.slvErr;

endmodule

// *** sim/sau_mem_model.sv ***
// Data memory behind the store port, byte addressed.
// Assumes a write lands at the edge that sees memWrEn high.
`timescale 1ns/100ps
module sau_mem_model (
  // Store port
  input wire logic        core_clk,
  input wire logic        memWrEn,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWrData,
  input wire logic [3:0]  memByteEn
);
  logic [7:0] mem [logic [31:0]];
  always @(posedge core_clk) begin
    if (memWrEn) begin
      for (int i = 0; i < 4; i++) begin
        if (memByteEn[i]) begin
          mem[{memAddr[31:2], 2'h0} + 32'(i)] = memWrData[8*i +: 8];
        end
      end
    end
  end
  // Unwritten bytes read as zero so a stray write shows up
  function automatic logic [7:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction
endmodule

// *** sim/sau_store_assertions.sv ***
// Port-level checks for the store unit.
// Assumes it is bound to sau_store_unit and sees its ports only.
`timescale 1ns/100ps
module sau_store_assertions
  import sau_pkg::*;
(
  // Clock, reset, issue
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        issueValid,
  input wire logic        issuePredTrue,
  input wire logic        issueLongForm,
  input wire logic        issueBaseSel,
  input wire logic        issueSrcSel,
  input wire logic [2:0]  issueAccess,
  input wire logic [3:0]  issueMode,
  input wire logic [4:0]  issueBaseIdx,
  input wire logic [14:0] issueOffsetField,
  input wire logic [31:0] baseValA,
  input wire logic [31:0] baseValB,
  input wire logic [31:0] srcValA,
  input wire logic [31:0] srcValB,
  input wire logic [31:0] globalBaseZero,
  input wire logic [31:0] globalBaseOne,
  // Results
  input wire logic        unitOneBusy,
  input wire logic        unitTwoBusy,
  input wire logic        baseWrEn,
  input wire logic [4:0]  baseWrIdx,
  input wire logic        memWrEn,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWrData,
  input wire logic [3:0]  memByteEn
);
  logic        go;
  logic [31:0] srcV;
  logic [31:0] longAdr;
  assign go = issueValid && issuePredTrue && (issueAccess inside {ACC_BYTE, ACC_HALF, ACC_WORD});
  assign srcV = issueSrcSel ? srcValB : srcValA;
  // Long form never wraps, so a plain sum is the reference
  assign longAdr = (issueBaseSel ? globalBaseOne : globalBaseZero)
                 + ({17'h0_0000, issueOffsetField}
                    << ((issueAccess == ACC_WORD) ? 2 : (issueAccess == ACC_HALF) ? 1 : 0));
  //////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  mem_latency_a: assert property (go |-> ##2 memWrEn)
    else $error("store write missing");
  false_nowrite_a: assert property (issueValid && !issuePredTrue |-> ##2 !memWrEn)
    else $error("false predicate wrote memory");
  long_addr_a: assert property (go && issueLongForm |-> ##2 memAddr == $past(longAdr, 2))
    else $error("long form address wrong");
  long_nowb_a: assert property (go && issueLongForm |=> !baseWrEn)
    else $error("long form updated a base");
  unit_sel_a: assert property (go |-> unitTwoBusy == (issueLongForm || issueBaseSel))
    else $error("wrong data unit busy");
  unit_one_a: assert property (go |-> unitOneBusy == (!issueLongForm && !issueBaseSel))
    else $error("unit one busy wrong");
  word_data_a: assert property (go && issueAccess == ACC_WORD |-> ##2
    memByteEn == 4'hF && memWrData == $past(srcV, 2)) else $error("word data wrong");
  wb_pulse_a: assert property (go && !issueLongForm && issueMode[MD_MODIFY] |=>
    baseWrEn && baseWrIdx == $past(issueBaseIdx)) else $error("base write missing");
  post_addr_a: assert property (go && !issueLongForm && issueMode[MD_POST] |-> ##2
    memAddr == $past(issueBaseSel ? baseValB : baseValA, 2)) else $error("post address wrong");
endmodule

bind sau_store_unit sau_store_assertions sau_store_assertions_inst (.*);

// *** sim/sau_store_unit_tb.sv ***
// Self-checking bench for the store unit.
// Assumes the memory model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module sau_store_unit_tb;
  import sau_pkg::*;
  logic        core_clk = 1'b0, sys_rst = 1'b1, issueValid = 1'b0, issuePredTrue = 1'b0;
  logic        issueLongForm = 1'b0, issueBaseSel = 1'b0, issueSrcSel = 1'b0;
  logic [2:0]  issueAccess = ACC_BYTE;
  logic [3:0]  issueMode = 4'h0;
  logic [4:0]  issueBaseIdx = 5'h00;
  logic [14:0] issueOffsetField = 15'h0000;
  logic [31:0] baseValA = 32'h0, baseValB = 32'h0, offsetValA = 32'h0, offsetValB = 32'h0;
  logic [31:0] srcValA = 32'h0, srcValB = 32'h0, globalBaseZero = 32'h0, globalBaseOne = 32'h0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        unitOneBusy, unitTwoBusy, baseWrEn, baseWrFileB, memWrEn, pready, pslverr;
  logic [4:0]  baseWrIdx;
  logic [31:0] baseWrData, memAddr, memWrData, prdata;
  logic [3:0]  memByteEn;
  int          n_mismatch = 0;
  int          tests_run = 0;

  sau_store_unit sau_store_unit_inst (.*);
  sau_mem_model sau_mem_model_inst (.*);

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  //////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [31:0] rdm(input logic [31:0] a);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) r[8*i +: 8] = sau_mem_model_inst.peek(a + 32'(i));
    return r;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk($sformatf("read %h", a), e, r);
    chk($sformatf("slverr %h", a), {31'h0, ee}, {31'h0, er});
  endtask

  // Issues one store and follows it through write-back and memory
  task automatic st(input logic lf, y, ss, pt, input logic [2:0] acc, input logic [3:0] md,
                    input logic [4:0] idx, input logic [14:0] off, input logic [31:0] ea, ewd,
                    input logic ewe, emw);
    logic [31:0] old, m, sv;
    logic [3:0]  be;
    old = rdm(ea);
    m = acc == ACC_BYTE ? 32'h0000_00FF : acc == ACC_HALF ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    be = acc == ACC_BYTE ? 4'h1 << ea[1:0] : acc == ACC_HALF ? (ea[1] ? 4'hC : 4'h3) : 4'hF;
    @(posedge core_clk);
    {issueValid, issuePredTrue, issueLongForm, issueBaseSel, issueSrcSel} <= {1'b1, pt, lf, y, ss};
    {issueAccess, issueMode, issueBaseIdx, issueOffsetField} <= {acc, md, idx, off};
    @(posedge core_clk);
    issueValid <= 1'b0;
    sv = ss ? srcValB : srcValA;
    #1 chk("baseWrEn", {31'h0, ewe}, {31'h0, baseWrEn});
    if (ewe) chk("baseWrData", ewd, baseWrData);
    if (ewe) chk("baseWrFileB", {31'h0, y}, {31'h0, baseWrFileB});
    chk("early mem", old, rdm(ea));
    @(posedge core_clk);
    #1 chk("memWrEn", {31'h0, emw}, {31'h0, memWrEn});
    if (emw) chk("memAddr", ea, memAddr);
    if (emw) chk("memByteEn", {28'h0, be}, {28'h0, memByteEn});
    @(posedge core_clk);
    #1 chk("mem data", emw ? (old & ~m) | (sv & m) : old, rdm(ea));
  endtask
  //////////////////////////////////////////
  task automatic t_long();
    logic [2:0] accs [3] = '{ACC_BYTE, ACC_HALF, ACC_WORD};
    logic [31:0] ea;
    @(posedge core_clk);
    {globalBaseZero, globalBaseOne} <= {32'h0000_1000, 32'h0000_2000};
    {srcValA, srcValB} <= {32'h9A32_7634, 32'h1357_9BDF};
    // Every base field is circular here, the long form must still add linearly
    wr(REG_AMODE, 32'h03FF_FFFF);
    rdchk(REG_AMODE, 32'h03FF_FFFF, 1'b0);
    for (int a = 0; a < 3; a++) begin
      for (int y = 0; y < 2; y++) begin
        ea = (y ? 32'h0000_2000 : 32'h0000_1000) + (32'h0000_7FFF << a);
        st(1'b1, y[0], y[0] ^ a[0], 1'b1, accs[a], 4'h9, 5'h05, 15'h7FFF, ea, 32'h0,
           1'b0, 1'b1);
      end
    end
  endtask

  task automatic t_modes();
    logic [3:0] mds [5] = '{4'hD, 4'hF, 4'hA, 4'h4, 4'hC};
    logic [31:0] b, o, s;
    @(posedge core_clk);
    {baseValA, baseValB, offsetValA, offsetValB} <= {32'h100, 32'h400, 32'h2, 32'h3};
    wr(REG_AMODE, AMODE_RST);
    for (int i = 0; i < 5; i++) begin
      b = i[0] ? 32'h0000_0400 : 32'h0000_0100;
      o = mds[i][2] ? (i[0] ? 32'h3 : 32'h2) : 32'h5;
      s = mds[i][0] ? b + (o << 2) : b - (o << 2);
      st(1'b0, i[0], ~i[0], 1'b1, ACC_WORD, mds[i], 5'h0A, 15'h0005, mds[i][1] ? b : s, s,
         mds[i][3], 1'b1);
    end
  endtask

  task automatic t_circ();
    @(posedge core_clk);
    {baseValA, baseValB} <= {32'h0000_100C, 32'h0000_2004};
    // Base 5 of file A wraps in a 16-byte block, base 6 of file B in an
    // 8-byte block of the second size, so one word past the end wraps
    wr(REG_AMODE, 32'h0043_2004);
    st(1'b0, 1'b0, 1'b0, 1'b1, ACC_WORD, 4'h9, 5'h05, 15'h0001, 32'h0000_1000,
       32'h0000_1000, 1'b1, 1'b1);
    st(1'b0, 1'b1, 1'b0, 1'b1, ACC_WORD, 4'h9, 5'h06, 15'h0001, 32'h0000_2000,
       32'h0000_2000, 1'b1, 1'b1);
  endtask

  task automatic t_refuse();
    st(1'b0, 1'b1, 1'b1, 1'b0, ACC_WORD, 4'hD, 5'h0A, 15'h0001, 32'h0000_2010, 32'h0,
       1'b0, 1'b0);
    st(1'b1, 1'b0, 1'b0, 1'b1, 3'h1, 4'h0, 5'h0A, 15'h0001, 32'h0000_1001, 32'h0,
       1'b0, 1'b0);
    rdchk(REG_COUNT, 32'h0000_000D, 1'b0);
    rdchk(REG_LASTADR, 32'h0000_2000, 1'b0);
    rdchk(REG_FAULT, 32'h0000_0002, 1'b0);
    wr(REG_FAULT, 32'h0000_0002);
    rdchk(REG_FAULT, ZERO_WORD, 1'b0);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdchk(REG_AMODE, AMODE_RST, 1'b0);
    rdchk(REG_COUNT, ZERO_WORD, 1'b0);
    rdchk(12'h010, ZERO_WORD, 1'b1);
    t_long();
    t_modes();
    t_circ();
    t_refuse();
    close_out();
  end

  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
endmodule
